// ---- rsml_pkg.sv ----
package rsml_pkg;

  // clock and link timing, times in their own unit
  localparam longint CLK_MHZ       = 125;
  localparam longint BIT_TIME_NS   = 104170;
  localparam longint IDLE_TIME_NS  = 1041700;
  localparam longint PERIOD_NS     = 500000000;
  localparam longint RESYNC_BITS   = 12;

  // cycle counts derived from the rate; bit rounds down, idle rounds up
  localparam longint BIT_CYC       = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam longint IDLE_CYC      = (IDLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam longint PERIOD_CYC    = (PERIOD_NS * CLK_MHZ) / 1000;
  localparam longint RESYNC_CYC    = RESYNC_BITS * BIT_CYC;

  localparam int     CNT_W         = 27;
  localparam int     IDX_W         = 9;
  localparam int     FIFO_W        = 8;
  localparam int     FIFO_D        = 16;
  localparam int     FIFO_CNT_W    = 5;

  // node and message codes
  localparam logic [7:0] OWN_ID       = 8'h6B;  // arbitrary value
  localparam logic [7:0] SERVICE_CODE = 8'hA7;  // arbitrary value
  localparam logic [7:0] MIN_NODE_ID  = 8'h80;
  localparam logic [7:0] MID_MEAS     = 8'hBE;
  localparam logic [7:0] MID_PDATA    = 8'hC1;
  localparam logic [7:0] MID_PROG     = 8'hC0;
  localparam logic [7:0] MID_DIAG     = 8'hD5;

  // measurement message layout, zero based byte index
  localparam logic [7:0] MEAS_REM     = 8'h0E;
  localparam logic [7:0] MEAS_NDATA   = 8'h0C;
  localparam logic [4:0] IX_SRC       = 5'h00;
  localparam logic [4:0] IX_SVC       = 5'h01;
  localparam logic [4:0] IX_DST       = 5'h02;
  localparam logic [4:0] IX_REM       = 5'h03;
  localparam logic [4:0] IX_MID       = 5'h04;
  localparam logic [4:0] IX_NDATA     = 5'h05;
  localparam logic [4:0] IX_CHK       = 5'h12;
  localparam logic [FIFO_CNT_W-1:0] MEAS_FIFO_NEED = 5'h0C;
  localparam logic [7:0] REM_NODATA   = 8'h01;
  localparam logic [7:0] REM_OVERHEAD = 8'h02;

  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic       LINE_IDLE    = 1'b1;
  localparam logic       LINE_START   = 1'b0;

  typedef enum logic [1:0] {
    RSML_TX_IDLE  = 2'b00,
    RSML_TX_START = 2'b01,
    RSML_TX_DATA  = 2'b11,
    RSML_TX_STOP  = 2'b10
  } rsml_tx_st_t;

  typedef enum logic [2:0] {
    RSML_RX_HUNT  = 3'b000,
    RSML_RX_IDLE  = 3'b001,
    RSML_RX_START = 3'b011,
    RSML_RX_DATA  = 3'b010,
    RSML_RX_STOP  = 3'b110
  } rsml_rx_st_t;

endpackage

// ---- rsml_fifo.sv ----
`timescale 1ns/10ps
module rsml_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_wr_valid,
  input  wire logic [W-1:0]           i_wr_data,
  output logic                        o_wr_ready,
  output logic                        o_rd_valid,
  output logic [W-1:0]                o_rd_data,
  input  wire logic                   i_rd_ready,
  output logic [$clog2(D+1)-1:0]      o_count
);

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr_ptr;
    logic [AW-1:0]       rd_ptr;
    logic [CW-1:0]       cnt;
    logic                full;
  } rsml_fifo_st_t;

  rsml_fifo_st_t q;
  rsml_fifo_st_t d;
  logic          push;
  logic          pop;

  // full is a flop so the filling side sees a registered ready
  always_comb begin
    d    = q;
    push = i_wr_valid && !q.full;
    pop  = i_rd_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wr_ptr] = i_wr_data;
      d.wr_ptr        = (q.wr_ptr == AW'(D-1)) ? '0 : q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == AW'(D-1)) ? '0 : q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.full = (d.cnt == CW'(D));
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_wr_ready = !q.full;
  assign o_rd_valid = (q.cnt != '0);
  assign o_rd_data  = q.mem[q.rd_ptr];
  assign o_count    = q.cnt;

endmodule

// ---- rsml_link.sv ----
`timescale 1ns/10ps
module rsml_link
  import rsml_pkg::*;
#(
  parameter int P_BIT_CYC    = int'(BIT_CYC),
  parameter int P_IDLE_CYC   = int'(IDLE_CYC),
  parameter int P_PERIOD_CYC = int'(PERIOD_CYC),
  parameter int P_RESYNC_CYC = int'(RESYNC_CYC)
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_rx,
  output logic            o_tx,
  output logic            o_tx_oe,
  input  wire logic       i_enable,
  input  wire logic [7:0] i_dest_id,
  input  wire logic       i_meas_valid,
  input  wire logic [7:0] i_meas_data,
  output logic            o_meas_ready,
  output logic            o_bcast_done,
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_src,
  output logic [7:0]      o_cmd_msg_id,
  output logic [7:0]      o_cmd_rem,
  output logic            o_frame_err,
  output logic            o_sum_err,
  output logic            o_sync_lost
);

  localparam logic [CNT_W-1:0] BIT_RELOAD  = CNT_W'(P_BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_RELOAD = CNT_W'(P_BIT_CYC / 2 - 1);
  localparam logic [CNT_W-1:0] IDLE_MIN    = CNT_W'(P_IDLE_CYC);
  localparam logic [CNT_W-1:0] RESYNC_MIN  = CNT_W'(P_RESYNC_CYC);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(P_PERIOD_CYC - 1);

  typedef struct packed {
    rsml_tx_st_t      tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic [4:0]       tx_idx;
    logic [7:0]       tx_sum;
    logic             tx_line;
    logic             tx_oe;
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] per_cnt;
    logic             pend;
    rsml_rx_st_t      rx_st;
    logic [CNT_W-1:0] rx_cnt;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic [IDX_W-1:0] rx_idx;
    logic [7:0]       rx_sum;
    logic             rx_ok;
    logic [7:0]       rx_rem;
    logic [7:0]       rx_mid;
    logic [7:0]       rx_src;
    logic             bcast_done;
    logic             cmd_valid;
    logic [7:0]       cmd_src;
    logic [7:0]       cmd_mid;
    logic [7:0]       cmd_rem;
    logic             frame_err;
    logic             sum_err;
    logic             sync_lost;
  } rsml_st_t;

  rsml_st_t               q;
  rsml_st_t               d;
  logic                   tx_pop;
  logic                   fifo_valid;
  logic [7:0]             fifo_data;
  logic [FIFO_CNT_W-1:0]  fifo_count;
  logic [7:0]             nbyte;
  logic [7:0]             rbyte;
  logic [7:0]             rsum;
  logic [IDX_W-1:0]       end_idx;

  // broadcast data waits here; the header is built on the fly
  rsml_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_wr_valid (i_meas_valid),
    .i_wr_data  (i_meas_data),
    .o_wr_ready (o_meas_ready),
    .o_rd_valid (fifo_valid),
    .o_rd_data  (fifo_data),
    .i_rd_ready (tx_pop),
    .o_count    (fifo_count)
  );

  // byte of the measurement message at a given index
  function automatic logic [7:0] meas_byte(
    input logic [4:0] idx,
    input logic [7:0] dest,
    input logic [7:0] data,
    input logic [7:0] sum
  );
    logic [7:0] b;
    b = data;
    unique case (idx)
      IX_SRC:   b = OWN_ID;
      IX_SVC:   b = SERVICE_CODE;
      IX_DST:   b = dest | MIN_NODE_ID;
      IX_REM:   b = MEAS_REM;
      IX_MID:   b = MID_MEAS;
      IX_NDATA: b = MEAS_NDATA;
      IX_CHK:   b = 8'(~sum + 8'h01);
      default:  b = data;
    endcase
    return b;
  endfunction

  always_comb begin
    d            = q;
    d.bcast_done = 1'b0;
    d.cmd_valid  = 1'b0;
    d.frame_err  = 1'b0;
    d.sum_err    = 1'b0;
    tx_pop       = 1'b0;
    rbyte        = {i_rx, q.rx_sh[7:1]};
    rsum         = 8'(q.rx_sum + rbyte);
    end_idx      = IDX_W'(IX_MID) + IDX_W'(q.rx_rem);
    nbyte        = meas_byte(q.tx_idx + 5'h01, i_dest_id, fifo_data, q.tx_sum);

    // time the line has been high; shared by idle wait and resync
    if (i_rx == LINE_IDLE) begin
      if (q.hi_cnt != RESYNC_MIN) begin
        d.hi_cnt = q.hi_cnt + 1'b1;
      end
    end else begin
      d.hi_cnt = '0;
    end

    // transmitter: one character per pass through start, data, stop
    unique case (q.tx_st)
      RSML_TX_IDLE: begin
        d.tx_oe   = 1'b0;
        d.tx_line = LINE_IDLE;
        // waiting for a full data set keeps the message free of gaps
        if (q.pend && i_enable && (q.hi_cnt >= IDLE_MIN) &&
            (fifo_count >= MEAS_FIFO_NEED) && (q.rx_st == RSML_RX_IDLE)) begin
          d.pend    = 1'b0;
          d.tx_idx  = IX_SRC;
          d.tx_sh   = OWN_ID;
          d.tx_sum  = OWN_ID;
          d.tx_cnt  = BIT_RELOAD;
          d.tx_oe   = 1'b1;
          d.tx_line = LINE_START;
          d.tx_st   = RSML_TX_START;
        end
      end
      RSML_TX_START: begin
        if (q.tx_cnt == '0) begin
          d.tx_cnt  = BIT_RELOAD;
          d.tx_bit  = '0;
          d.tx_line = q.tx_sh[0];
          d.tx_st   = RSML_TX_DATA;
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
      RSML_TX_DATA: begin
        if (q.tx_cnt == '0) begin
          d.tx_cnt = BIT_RELOAD;
          if (q.tx_bit == BIT_LAST) begin
            d.tx_line = LINE_IDLE;
            d.tx_st   = RSML_TX_STOP;
          end else begin
            d.tx_bit  = q.tx_bit + 1'b1;
            d.tx_sh   = {1'b0, q.tx_sh[7:1]};
            d.tx_line = q.tx_sh[1];
          end
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
      RSML_TX_STOP: begin
        if (q.tx_cnt == '0) begin
          if (q.tx_idx == IX_CHK) begin
            d.tx_oe      = 1'b0;
            d.tx_line    = LINE_IDLE;
            d.bcast_done = 1'b1;
            d.tx_st      = RSML_TX_IDLE;
          end else begin
            // next character follows back to back, no idle in between
            d.tx_idx  = q.tx_idx + 5'h01;
            d.tx_sh   = nbyte;
            d.tx_sum  = 8'(q.tx_sum + nbyte);
            tx_pop    = fifo_valid && (q.tx_idx >= IX_NDATA) && (q.tx_idx < IX_CHK - 5'h01);
            d.tx_cnt  = BIT_RELOAD;
            d.tx_line = LINE_START;
            d.tx_st   = RSML_TX_START;
          end
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
    endcase

    // half second timer; a tick in the start cycle is not lost
    if (i_enable) begin
      if (q.per_cnt == PERIOD_LAST) begin
        d.per_cnt = '0;
        d.pend    = 1'b1;
      end else begin
        d.per_cnt = q.per_cnt + 1'b1;
      end
    end else begin
      d.per_cnt = '0;
      d.pend    = 1'b0;
    end

    // receiver: mid-bit sampling, own echo ignored while driving
    unique case (q.rx_st)
      RSML_RX_HUNT: begin
        if (q.hi_cnt >= RESYNC_MIN) begin
          d.sync_lost = 1'b0;
          d.rx_idx    = '0;
          d.rx_st     = RSML_RX_IDLE;
        end
      end
      RSML_RX_IDLE: begin
        // a long idle ends any half-received message
        if ((q.hi_cnt >= RESYNC_MIN) || q.tx_oe) begin
          d.rx_idx = '0;
        end
        if (!q.tx_oe && (i_rx == LINE_START)) begin
          d.rx_cnt = HALF_RELOAD;
          d.rx_st  = RSML_RX_START;
        end
      end
      RSML_RX_START: begin
        if (q.rx_cnt == '0) begin
          // a start too short to reach mid-bit is taken as a glitch
          d.rx_cnt = BIT_RELOAD;
          d.rx_bit = '0;
          d.rx_st  = (i_rx == LINE_START) ? RSML_RX_DATA : RSML_RX_IDLE;
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RSML_RX_DATA: begin
        if (q.rx_cnt == '0) begin
          d.rx_cnt = BIT_RELOAD;
          d.rx_sh  = rbyte;
          d.rx_bit = q.rx_bit + 1'b1;
          if (q.rx_bit == BIT_LAST) begin
            d.rx_st = RSML_RX_STOP;
          end
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RSML_RX_STOP: begin
        if (q.rx_cnt == '0) begin
          rbyte = q.rx_sh;
          rsum  = 8'(q.rx_sum + rbyte);
          if (i_rx != LINE_IDLE) begin
            d.frame_err = 1'b1;
            d.sync_lost = 1'b1;
            d.rx_idx    = '0;
            d.rx_st     = RSML_RX_HUNT;
          end else begin
            d.rx_st  = RSML_RX_IDLE;
            d.rx_idx = q.rx_idx + 1'b1;
            d.rx_sum = rsum;
            unique case (q.rx_idx)
              IDX_W'(IX_SRC): begin
                d.rx_src = rbyte;
                d.rx_sum = rbyte;
                d.rx_ok  = (rbyte >= MIN_NODE_ID);
              end
              IDX_W'(IX_SVC): d.rx_ok = q.rx_ok && (rbyte == SERVICE_CODE);
              IDX_W'(IX_DST): d.rx_ok = q.rx_ok && (rbyte == OWN_ID);
              IDX_W'(IX_REM): begin
                d.rx_rem = rbyte;
                d.rx_ok  = q.rx_ok && (rbyte != 8'h00);
              end
              default: begin
                if (q.rx_idx == IDX_W'(IX_MID)) begin
                  d.rx_mid = rbyte;
                end
                if ((q.rx_idx == IDX_W'(IX_NDATA)) && (q.rx_rem != REM_NODATA) &&
                    (rbyte != 8'(q.rx_rem - REM_OVERHEAD))) begin
                  d.rx_ok = 1'b0;
                end
                if ((q.rx_idx > IDX_W'(IX_MID)) && (q.rx_idx == end_idx)) begin
                  d.rx_idx = '0;
                  if (rsum != 8'h00) begin
                    d.sum_err = 1'b1;
                  end else if (q.rx_ok &&
                               ((q.rx_mid == MID_PROG) || (q.rx_mid == MID_DIAG))) begin
                    d.cmd_valid = 1'b1;
                    d.cmd_src   = q.rx_src;
                    d.cmd_mid   = q.rx_mid;
                    d.cmd_rem   = q.rx_rem;
                  end
                end
              end
            endcase
          end
        end else begin
          d.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      default: begin
        d.rx_st = RSML_RX_HUNT;
      end
    endcase
  end

  // reset starts out of sync so a running bus is never joined mid-character
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q           <= '0;
      q.tx_st     <= RSML_TX_IDLE;
      q.tx_line   <= LINE_IDLE;
      q.rx_st     <= RSML_RX_HUNT;
      q.sync_lost <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_tx         = q.tx_line;
  assign o_tx_oe      = q.tx_oe;
  assign o_bcast_done = q.bcast_done;
  assign o_cmd_valid  = q.cmd_valid;
  assign o_cmd_src    = q.cmd_src;
  assign o_cmd_msg_id = q.cmd_mid;
  assign o_cmd_rem    = q.cmd_rem;
  assign o_frame_err  = q.frame_err;
  assign o_sum_err    = q.sum_err;
  assign o_sync_lost  = q.sync_lost;

endmodule

// ---- rsml_link_properties.sv ----
`timescale 1ns/10ps
module rsml_link_properties
  import rsml_pkg::*;
#(
  parameter int P_BIT_CYC    = 16,
  parameter int P_IDLE_CYC   = 160,
  parameter int P_RESYNC_CYC = 192
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_rx,
  input wire logic       i_enable,
  input wire logic       o_tx,
  input wire logic       o_tx_oe,
  input wire logic       o_bcast_done,
  input wire logic       o_cmd_valid,
  input wire logic [7:0] o_cmd_src,
  input wire logic [7:0] o_cmd_msg_id,
  input wire logic       o_sum_err,
  input wire logic       o_frame_err,
  input wire logic       o_sync_lost
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  int ph_q, bix_q, len_q, hi_q;
  // bit phase and bit number of the driven character, driven length, high run
  always_ff @(posedge i_mclk) begin
    ph_q  <= (!o_tx_oe || ph_q == P_BIT_CYC - 1) ? 0 : ph_q + 1;
    bix_q <= !o_tx_oe ? 0 : (ph_q != P_BIT_CYC - 1) ? bix_q : (bix_q == 9) ? 0 : bix_q + 1;
    len_q <= o_tx_oe ? len_q + 1 : 0;
    hi_q  <= i_rx ? hi_q + 1 : 0;
  end
  // driver drops after nineteen whole characters, done in that cycle
  sequence s_end;
    (len_q == 190 * P_BIT_CYC) ##0 o_bcast_done;
  endsequence
  a_idle_high: assert property (!o_tx_oe |-> o_tx)
    else $error("line not high while released");
  a_start_low: assert property (o_tx_oe && bix_q == 0 |-> !o_tx)
    else $error("start bit not low");
  a_stop_high: assert property (o_tx_oe && bix_q == 9 |-> o_tx)
    else $error("stop bit not high");
  a_bit_edge: assert property (o_tx_oe && $past(o_tx_oe) && $changed(o_tx)
      |-> ph_q == 0)
    else $error("tx changed inside a bit");
  a_frame_len: assert property ($fell(o_tx_oe) |-> s_end)
    else $error("broadcast length wrong");
  a_done_fell: assert property (o_bcast_done |-> $fell(o_tx_oe))
    else $error("done without end of drive");
  a_idle_before: assert property ($rose(o_tx_oe) |-> hi_q >= P_IDLE_CYC)
    else $error("drive started without idle");
  a_oe_enable: assert property ($rose(o_tx_oe) |-> $past(i_enable))
    else $error("drive started while disabled");
  a_frame_sync: assert property (o_frame_err |-> ##[0:1] o_sync_lost)
    else $error("framing error kept alignment");
  a_resync_wait: assert property ($fell(o_sync_lost) |-> hi_q >= P_RESYNC_CYC - 1)
    else $error("alignment regained early");
  a_cmd_ok: assert property (o_cmd_valid |-> o_cmd_src[7] && !o_sum_err
      && (o_cmd_msg_id == MID_PROG || o_cmd_msg_id == MID_DIAG))
    else $error("bad command accepted");
endmodule
bind rsml_link rsml_link_properties #(
  .P_BIT_CYC(P_BIT_CYC), .P_IDLE_CYC(P_IDLE_CYC), .P_RESYNC_CYC(P_RESYNC_CYC)
) u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_rx(i_rx), .i_enable(i_enable), .o_tx(o_tx),
  .o_tx_oe(o_tx_oe), .o_bcast_done(o_bcast_done), .o_cmd_valid(o_cmd_valid),
  .o_cmd_src(o_cmd_src), .o_cmd_msg_id(o_cmd_msg_id), .o_sum_err(o_sum_err),
  .o_frame_err(o_frame_err), .o_sync_lost(o_sync_lost)
);

// ---- rsml_node_model.sv ----
`timescale 1ns/10ps
module rsml_node_model #(
  parameter int P_BIT_CYC = 16
) (
  input  wire logic i_mclk,
  input  wire logic i_tx,
  input  wire logic i_tx_oe,
  output logic      o_rx
);
  logic drv = 1'b1;
  int   rxq[$];
  // pull-up keeps the bus high unless a driver pulls it
  assign o_rx = i_tx_oe ? i_tx : drv;
  // release the bus for n bit times
  task automatic hold(input int n);
    drv = 1'b1;
    repeat (n * P_BIT_CYC) @(negedge i_mclk);
  endtask
  // one character, stop level chosen so a framing fault can be made
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv = f[i];
      repeat (P_BIT_CYC) @(negedge i_mclk);
    end
  endtask
  // sample the device mid-bit; bit 8 set marks a low stop
  initial begin
    logic [8:0] s;
    forever begin
      @(posedge i_mclk);
      if (i_tx_oe === 1'b1 && i_tx === 1'b0) begin
        repeat (P_BIT_CYC / 2) @(posedge i_mclk);
        for (int i = 0; i < 9; i++) begin
          repeat (P_BIT_CYC) @(posedge i_mclk);
          s[i] = i_tx;
        end
        rxq.push_back({~s[8], s[7:0]});
      end
    end
  end
endmodule

// ---- tb_rs485_sensor_message_link.sv ----
`timescale 1ns/10ps
module tb_rs485_sensor_message_link;
  import rsml_pkg::*;
  localparam int BC  = 16;
  localparam int PER = 3000;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_enable = 1'b0;
  logic        i_meas_valid = 1'b0;
  logic [7:0]  i_dest_id = 8'h00;
  logic [7:0]  i_meas_data = 8'h00;
  logic [7:0]  o_cmd_src, o_cmd_msg_id, o_cmd_rem;
  logic        o_tx, o_tx_oe, o_meas_ready, o_bcast_done;
  logic        o_cmd_valid, o_frame_err, o_sum_err, o_sync_lost;
  wire         rx;
  int          errors, samples_checked, n_cmd, n_sum, n_frm, n_done;
  logic [31:0] seed = 32'h0000003E;
  logic [7:0]  mq[$];
  logic [7:0]  srcs[8] = '{8'hB1, 8'h90, 8'h80, 8'h7F, 8'hB1, 8'hB1, 8'hB1, 8'hB1};
  logic [7:0]  ids[8] = '{8'hC0, 8'hD5, 8'hC0, 8'hC0, 8'hC0, 8'hD5, 8'hBE, 8'hC0};
  int          nds[8] = '{0, 3, 2, 0, 0, 0, 0, 0};

  rsml_link #(.P_BIT_CYC(BC), .P_IDLE_CYC(10 * BC), .P_PERIOD_CYC(PER),
    .P_RESYNC_CYC(12 * BC)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_rx(rx), .o_tx(o_tx), .o_tx_oe(o_tx_oe),
    .i_enable(i_enable), .i_dest_id(i_dest_id), .i_meas_valid(i_meas_valid),
    .i_meas_data(i_meas_data), .o_meas_ready(o_meas_ready), .o_bcast_done(o_bcast_done),
    .o_cmd_valid(o_cmd_valid), .o_cmd_src(o_cmd_src), .o_cmd_msg_id(o_cmd_msg_id),
    .o_cmd_rem(o_cmd_rem), .o_frame_err(o_frame_err), .o_sum_err(o_sum_err),
    .o_sync_lost(o_sync_lost));
  rsml_node_model #(.P_BIT_CYC(BC)) p (.i_mclk(i_mclk), .i_tx(o_tx), .i_tx_oe(o_tx_oe),
    .o_rx(rx));

  initial forever #4 i_mclk = ~i_mclk;
  // pulse counters feeding the bench checks
  always @(posedge i_mclk) begin
    n_cmd  += (o_cmd_valid === 1'b1);
    n_sum  += (o_sum_err === 1'b1);
    n_frm  += (o_frame_err === 1'b1);
    n_done += (o_bcast_done === 1'b1);
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded wait; a hang counts as a mismatch and ends the run
  task automatic wait_done(input int d0, output int t);
    t = 0;
    while (n_done == d0 && t < 20000) begin
      @(negedge i_mclk);
      t++;
    end
    if (t == 20000) begin
      errors++;
      results();
    end
  endtask
  // whole message from a far node after a resync-length idle
  task automatic send_msg(input logic [7:0] src, svc, dst, id, input int nd, input logic bad);
    logic [7:0] m[$];
    logic [7:0] s;
    m = {src, svc, dst, 8'(nd == 0 ? 1 : nd + 2), id};
    if (nd > 0) m.push_back(8'(nd));
    repeat (nd) m.push_back(xs());
    s = 8'h00;
    foreach (m[i]) s += m[i];
    m.push_back(-s ^ {7'h00, bad});
    p.hold(14);
    foreach (m[i]) p.send(m[i], 1'b1);
    repeat (3 * BC) @(negedge i_mclk);
  endtask

  initial begin
    repeat (100000) @(posedge i_mclk);
    errors++;
    results();
  end

  initial begin
    logic [7:0] b[19];
    logic [7:0] hd[6];
    logic [7:0] s;
    logic [7:0] sv, dv;
    int n, f, t, c, m;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    chk("tx idle", 1, o_tx);
    chk("oe", 0, o_tx_oe);
    chk("sync lost", 1, o_sync_lost);
    // fill until refused, then broadcast twelve of the bytes
    for (int k = 0; k < 2; k++) begin
      f = mq.size();
      n = 0;
      i_meas_valid = 1'b1;
      while (o_meas_ready === 1'b1 && n < 20) begin
        i_meas_data = xs();
        mq.push_back(i_meas_data);
        @(negedge i_mclk);
        n++;
      end
      i_meas_data = xs();
      @(negedge i_mclk);
      i_meas_valid = 1'b0;
      chk("pushes", FIFO_D - f, n);
      i_dest_id = xs();
      i_enable = 1'b1;
      wait_done(n_done, t);
      i_enable = 1'b0;
      if (k == 0) chk("period", 1, t >= PER);
      repeat (BC) @(negedge i_mclk);
      hd = '{OWN_ID, SERVICE_CODE, i_dest_id | 8'h80, 8'h0E, 8'hBE, 8'h0C};
      s = 8'h00;
      for (int i = 0; i < 19; i++) begin
        if (i < 6) b[i] = hd[i];
        else if (i < 18) b[i] = mq.pop_front();
        else b[i] = -s;
        s += b[i];
      end
      chk("byte count", 19, p.rxq.size());
      for (int i = 0; i < 19; i++) begin
        chk("byte", b[i], p.rxq.pop_front());
      end
      $display("test broadcast %0d ended", k);
    end
    // commands: good, boundary id, and silence for low source, service, destination, message id and checksum
    for (int k = 0; k < 8; k++) begin
      c = n_cmd;
      m = n_sum;
      sv = SERVICE_CODE ^ {7'h00, k == 4};
      dv = OWN_ID ^ {7'h00, k == 5};
      send_msg(srcs[k], sv, dv, ids[k], nds[k], k == 7);
      chk("accepted", k < 3, n_cmd - c);
      chk("sum error", k == 7, n_sum - m);
      if (k < 3) begin
        chk("src", srcs[k], o_cmd_src);
        chk("id", ids[k], o_cmd_msg_id);
        chk("rem", nds[k] == 0 ? 1 : nds[k] + 2, o_cmd_rem);
      end
    end
    $display("test commands ended");
    // low stop bit, then a command after the resync idle
    f = n_frm;
    c = n_cmd;
    p.hold(14);
    p.send(8'h55, 1'b0);
    chk("frame error", 1, n_frm - f);
    chk("hunting", 1, o_sync_lost);
    send_msg(8'hC4, SERVICE_CODE, OWN_ID, 8'hD5, 0, 1'b0);
    chk("realigned", 0, o_sync_lost);
    chk("accepted", 1, n_cmd - c);
    $display("test framing ended");
    results();
  end
endmodule
